//--- hdl/dspm_serial.sv
// Function
// RULE1: two independent ports, own mode and speed
// RULE2: shift mode makes its clock, half duplex
// RULE3: async modes send and receive together
// RULE4: finished word held apart from shifter
// RULE5: buffer read gives receive, write loads transmit
// RULE6: control and buffer per port, adjacent
// RULE7: four modes per port, 0 to 3
// RULE8: mode 0 data on rxd, clock on txd
// RULE9: mode 0 partner is a pure slave
// RULE10: mode 0 clock is sysclk/12 or /4
// RULE11: mode 1 frame is ten bits
// RULE12: mode 1 stop bit stored as ninth bit
// RULE13: mode 1 rate from timer overflows
// RULE14: port 1 timer 1; port 0 timer 1/2
// RULE15: own doubler per port, doubles rate
// RULE16: mode 2 eleven bits, 32/64 clocks
// RULE17: mode 3 eleven bits, timer rate
// RULE18: buffer write sends; mode 0 receive start
// RULE19: ninth bit sent and stored via control
// RULE20: control bit layout mode..flags
// RULE21: mode number high bit is select 0
// RULE22: hardware sets done flags, software clears
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// one serial port
// ****************************************************************
module dspm_port (
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire dspm_pkg::dspm_req_t req,
   input  wire logic               rxd,
   input  wire logic               ovf,
   input  wire logic               dbl,
   output dspm_pkg::dspm_ctrl_t    ctrl,
   output logic [7:0]              rx_data,
   output dspm_pkg::dspm_pins_t    pins
);

   localparam int         HALF_OSR = dspm_pkg::OVERSAMPLE / 2 - 1;
   localparam logic [4:0] LIM2_S = 5'(dspm_pkg::M2_BIT_SLOW / dspm_pkg::OVERSAMPLE - 1);
   localparam logic [4:0] LIM2_F = 5'(dspm_pkg::M2_BIT_FAST / dspm_pkg::OVERSAMPLE - 1);
   localparam logic [4:0] LIMT_S = 5'(dspm_pkg::TMR_OVF_BIT_SLOW / dspm_pkg::OVERSAMPLE - 1);
   localparam logic [4:0] LIMT_F = 5'(dspm_pkg::TMR_OVF_BIT_FAST / dspm_pkg::OVERSAMPLE - 1);

   typedef struct packed {
      dspm_pkg::dspm_ctrl_t ctrl;
      logic [7:0]           rxbuf;
      logic [4:0]           pre;
      logic                 tick;
      logic                 tx_busy;
      logic [10:0]          tx_sh;
      logic [3:0]           tx_left;
      logic [3:0]           tx_cnt;
      logic                 rx_busy;
      logic                 rx_prev;
      logic [10:0]          rx_sh;
      logic [3:0]           rx_got;
      logic [3:0]           rx_cnt;
      dspm_pkg::dspm_m0_t   m0;
      logic [3:0]           m0_div;
      logic [2:0]           m0_bits;
      logic [7:0]           m0_sh;
      dspm_pkg::dspm_pins_t pins;
   } dspm_port_st_t;

   dspm_port_st_t        s;
   dspm_port_st_t        n;
   dspm_pkg::dspm_mode_t mode;
   dspm_pkg::dspm_ctrl_t cw;
   logic                 nine;
   logic [4:0]           lim;
   logic [3:0]           per;
   logic [3:0]           half;
   logic [10:0]          rx_new;
   logic                 tx_done;
   logic                 rx_done;
   logic [7:0]           rx_word;
   logic                 rx_nin;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      n       = s;
      n.tick  = 1'b0;
      tx_done = 1'b0;
      rx_done = 1'b0;
      rx_word = s.rxbuf;
      rx_nin  = s.ctrl.ninth_receive_bit;
      cw      = dspm_pkg::dspm_ctrl_t'(req.wdata);
      mode    = dspm_pkg::dspm_mode_t'({s.ctrl.mode_select_high_or_frame_error,
                                        s.ctrl.mode_select_low}); // RULE21 RULE7
      nine    = (mode == dspm_pkg::MODE_ASYNC9_FIXED) || (mode == dspm_pkg::MODE_ASYNC9_TIMER);
      per     = s.ctrl.clock_divide_select ? 4'(dspm_pkg::M0_DIV_FAST)
                                           : 4'(dspm_pkg::M0_DIV_SLOW); // RULE10
      half    = per >> 1;
      rx_new  = {rxd, s.rx_sh[10:1]};

      // oversample tick: mode 2 counts clocks, modes 1 and 3 count overflows
      if (mode == dspm_pkg::MODE_ASYNC9_FIXED) begin
         lim = dbl ? LIM2_F : LIM2_S; // RULE16 RULE15
      end else begin
         lim = dbl ? LIMT_F : LIMT_S; // RULE13 RULE15
      end
      if (mode == dspm_pkg::MODE_SHIFT) begin
         n.pre = 5'h00;
      end else if (mode == dspm_pkg::MODE_ASYNC9_FIXED || ovf) begin
         if (s.pre >= lim) begin
            n.pre  = 5'h00;
            n.tick = 1'b1;
         end else begin
            n.pre = s.pre + 5'h01;
         end
      end

      // software write to control; flag sets below override it
      if (req.wr_ctrl) begin
         n.ctrl = cw; // RULE20
      end

      // async transmit; a write while busy is ignored
      if (req.wr_buf && mode != dspm_pkg::MODE_SHIFT && !s.tx_busy) begin
         n.tx_busy = 1'b1; // RULE18 RULE5
         n.tx_cnt  = 4'h0;
         n.tx_sh   = {1'b1, (nine ? s.ctrl.ninth_transmit_bit : 1'b1), req.wdata, 1'b0}; // RULE19
         n.tx_left = nine ? dspm_pkg::FRAME_BITS_9 : dspm_pkg::FRAME_BITS_8; // RULE11 RULE16 RULE17
      end else if (s.tx_busy && s.tick) begin
         if (s.tx_cnt == 4'(dspm_pkg::OVERSAMPLE - 1)) begin
            n.tx_cnt  = 4'h0;
            n.tx_sh   = {1'b1, s.tx_sh[10:1]};
            n.tx_left = s.tx_left - 4'h1;
            if (s.tx_left == 4'h1) begin
               n.tx_busy = 1'b0;
               tx_done   = 1'b1;
            end
         end else begin
            n.tx_cnt = s.tx_cnt + 4'h1;
         end
      end

      // async receive runs beside transmit, sampling mid-bit
      n.rx_prev = rxd;
      if (!s.rx_busy) begin
         if (mode != dspm_pkg::MODE_SHIFT && s.ctrl.rx_enable && s.rx_prev && !rxd) begin
            n.rx_busy = 1'b1; // RULE3
            n.rx_cnt  = 4'h0;
            n.rx_got  = 4'h0;
         end
      end else if (s.tick) begin
         n.rx_cnt = s.rx_cnt + 4'h1;
         if (s.rx_cnt == 4'(HALF_OSR)) begin
            if (s.rx_got == 4'h0 && rxd) begin
               n.rx_busy = 1'b0; // glitch, not a start bit
            end else begin
               n.rx_sh  = rx_new;
               n.rx_got = s.rx_got + 4'h1;
               if (s.rx_got + 4'h1 == (nine ? dspm_pkg::FRAME_BITS_9 : dspm_pkg::FRAME_BITS_8)) begin
                  n.rx_busy = 1'b0;
                  rx_done   = 1'b1;
                  rx_word   = nine ? rx_new[8:1] : rx_new[9:2];
                  rx_nin    = nine ? rx_new[9] : rx_new[10]; // RULE12 RULE19
               end
            end
         end
      end

      // mode 0 engine: one direction at a time, clock made here
      case (s.m0)
         dspm_pkg::M0_IDLE: begin
            n.m0_div  = 4'h0;
            n.m0_bits = 3'h0;
            if (mode == dspm_pkg::MODE_SHIFT && req.wr_buf) begin
               n.m0    = dspm_pkg::M0_SEND; // RULE18 RULE2
               n.m0_sh = req.wdata;
            end else if (req.wr_ctrl && cw.rx_enable && !cw.rx_done_flag &&
                         !cw.mode_select_high_or_frame_error && !cw.mode_select_low) begin
               n.m0 = dspm_pkg::M0_RECV; // RULE18
            end
         end
         dspm_pkg::M0_SEND, dspm_pkg::M0_RECV: begin
            n.m0_div = s.m0_div + 4'h1;
            // sample where the clock rises; the partner changed data at the fall
            if (s.m0 == dspm_pkg::M0_RECV && s.m0_div == half - 4'h1) begin
               n.m0_sh = {rxd, s.m0_sh[7:1]};
            end
            if (s.m0_div == per - 4'h1) begin
               n.m0_div  = 4'h0;
               n.m0_bits = s.m0_bits + 3'h1;
               if (s.m0 == dspm_pkg::M0_SEND) begin
                  n.m0_sh = {1'b0, s.m0_sh[7:1]};
               end
               if (s.m0_bits == 3'h7) begin
                  n.m0 = dspm_pkg::M0_IDLE;
                  if (s.m0 == dspm_pkg::M0_SEND) begin
                     tx_done = 1'b1;
                  end else begin
                     rx_done = 1'b1;
                     rx_word = s.m0_sh;
                  end
               end
            end
         end
         default: n.m0 = dspm_pkg::M0_IDLE;
      endcase

      // a mode change abandons whatever the other kind of engine was doing;
      // the mode being written counts, so a write into mode 0 may start a receive
      if (!n.ctrl.mode_select_high_or_frame_error && !n.ctrl.mode_select_low) begin
         n.tx_busy = 1'b0;
         n.rx_busy = 1'b0;
      end else begin
         n.m0 = dspm_pkg::M0_IDLE;
      end

      // hardware set beats a software clear in the same cycle
      if (tx_done) begin
         n.ctrl.tx_done_flag = 1'b1; // RULE22
      end
      if (rx_done) begin
         n.ctrl.rx_done_flag      = 1'b1; // RULE22
         n.ctrl.ninth_receive_bit = rx_nin;
         n.rxbuf                  = rx_word; // RULE4
      end

      // pins follow the next state so they leave straight from flops
      if (n.m0 != dspm_pkg::M0_IDLE) begin
         n.pins.txd = (n.m0_div >= half); // RULE8
      end else begin
         n.pins.txd = n.tx_busy ? n.tx_sh[0] : 1'b1;
      end
      n.pins.rxd_o    = (n.m0 == dspm_pkg::M0_SEND) ? n.m0_sh[0] : 1'b1; // RULE8
      n.pins.rxd_oe_n = (n.m0 != dspm_pkg::M0_SEND);
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s          <= '0;
         s.ctrl     <= dspm_pkg::dspm_ctrl_t'(dspm_pkg::CTRL_RST);
         s.rx_prev  <= 1'b1;
         s.m0       <= dspm_pkg::M0_IDLE;
         s.pins     <= 3'b111;
      end else begin
         s <= n;
      end
   end

   assign ctrl    = s.ctrl;
   assign rx_data = s.rxbuf; // RULE5
   assign pins    = s.pins;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_low_slow;
      (!s.pins.txd) [*6];
   endsequence
   sequence s_high_slow;
      s.pins.txd [*6];
   endsequence

   a_m0_slow_clock: assert property ( // RULE10
      s.m0 != dspm_pkg::M0_IDLE && s.m0_div == 4'h0 && !s.ctrl.clock_divide_select
      |-> s_low_slow ##1 s_high_slow)
      else $error("mode 0 slow clock is not 6 low, 6 high");

   a_m0_fast_clock: assert property ( // RULE10
      s.m0 != dspm_pkg::M0_IDLE && s.m0_div == 4'h0 && s.ctrl.clock_divide_select
      |-> (!s.pins.txd) [*2] ##1 s.pins.txd [*2])
      else $error("mode 0 fast clock is not 2 low, 2 high");

   a_m0_half_duplex: assert property ( // RULE2
      s.m0 != dspm_pkg::M0_IDLE |-> !s.tx_busy && !s.rx_busy &&
      (s.pins.rxd_oe_n == (s.m0 == dspm_pkg::M0_RECV)))
      else $error("mode 0 engine overlaps or drives data wrongly");

   a_tx_flag_set: assert property ( // RULE22
      tx_done |=> s.ctrl.tx_done_flag)
      else $error("transmit flag not set after a frame");

   a_rx_flag_load: assert property ( // RULE4
      rx_done |=> s.ctrl.rx_done_flag && s.rxbuf == $past(rx_word))
      else $error("received word or flag not stored");

   a_stop_to_nine: assert property ( // RULE12
      rx_done && mode == dspm_pkg::MODE_ASYNC8 |=> s.ctrl.ninth_receive_bit == $past(rxd))
      else $error("mode 1 stop bit not stored");

   a_frame_ten_bits: assert property ( // RULE11
      $rose(s.tx_busy) && mode == dspm_pkg::MODE_ASYNC8
      |-> s.tx_left == dspm_pkg::FRAME_BITS_8 && !s.tx_sh[0] && s.tx_sh[9])
      else $error("mode 1 frame is not start, 8 data, stop");

   a_m2_tick_slow: assert property ( // RULE16
      s.tick && mode == dspm_pkg::MODE_ASYNC9_FIXED && !dbl |=> (!s.tick) [*3] ##1 s.tick)
      else $error("mode 2 slow tick spacing wrong");

   a_m2_tick_fast: assert property ( // RULE15
      s.tick && mode == dspm_pkg::MODE_ASYNC9_FIXED && dbl |=> !s.tick ##1 s.tick)
      else $error("mode 2 doubled tick spacing wrong");

   a_full_duplex: assert property ( // RULE3
      s.tx_busy && !s.rx_busy && mode != dspm_pkg::MODE_SHIFT && s.ctrl.rx_enable &&
      s.rx_prev && !rxd |=> s.rx_busy && s.tx_busy)
      else $error("receive start blocked by transmit");

   a_m0_rx_start: assert property ( // RULE18
      s.m0 == dspm_pkg::M0_IDLE && req.wr_ctrl && cw.rx_enable && !cw.rx_done_flag &&
      !cw.mode_select_high_or_frame_error && !cw.mode_select_low
      |=> s.m0 == dspm_pkg::M0_RECV)
      else $error("mode 0 receive not started");

endmodule

// ****************************************************************
// top: bus slave, pin synchronisers, two ports
// ****************************************************************
module dspm_serial (
   input  wire logic        CLOCK,
   input  wire logic        RST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        TIMER1_OVF,
   input  wire logic        TIMER2_OVF,
   input  wire logic        RXD0_I,
   output logic             RXD0_O,
   output logic             RXD0_OE_N,
   output logic             TXD0,
   input  wire logic        RXD1_I,
   output logic             RXD1_O,
   output logic             RXD1_OE_N,
   output logic             TXD1
);

   localparam logic [11:0] A_CTRL0 = 12'({dspm_pkg::CTRL0_IDX, 2'b00}); // RULE6
   localparam logic [11:0] A_BUF0  = 12'({dspm_pkg::BUF0_IDX, 2'b00});
   localparam logic [11:0] A_CTRL1 = 12'({dspm_pkg::CTRL1_IDX, 2'b00});
   localparam logic [11:0] A_BUF1  = 12'({dspm_pkg::BUF1_IDX, 2'b00});
   localparam logic [11:0] A_CFG   = 12'({dspm_pkg::CFG_IDX, 2'b00});

   typedef struct packed {
      logic [1:0]  rxd_meta;
      logic [1:0]  rxd_sync;
      logic [2:0]  cfg;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } dspm_top_st_t;

   dspm_top_st_t         s;
   dspm_top_st_t         n;
   logic [1:0]           rst_q;
   logic                 rst_n_s;
   logic                 setup;
   logic                 wr;
   logic                 hit;
   logic [7:0]           rd;
   dspm_pkg::dspm_req_t  req0;
   dspm_pkg::dspm_req_t  req1;
   dspm_pkg::dspm_ctrl_t ctrl0;
   dspm_pkg::dspm_ctrl_t ctrl1;
   logic [7:0]           rxb0;
   logic [7:0]           rxb1;
   dspm_pkg::dspm_pins_t pins0;
   dspm_pkg::dspm_pins_t pins1;
   logic                 ovf0;

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rst_q <= 2'b00;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n_s = rst_q[1];

   // bus decode: answer in the first access cycle, no wait states
   always_comb begin
      n          = s;
      n.rxd_meta = {RXD1_I, RXD0_I};
      n.rxd_sync = s.rxd_meta;
      setup      = PSEL && !PENABLE;
      hit        = 1'b1;
      case (PADDR)
         A_CTRL0: rd = ctrl0;
         A_BUF0:  rd = rxb0; // RULE5
         A_CTRL1: rd = ctrl1;
         A_BUF1:  rd = rxb1;
         A_CFG:   rd = {5'h00, s.cfg};
         default: begin
            rd  = 8'h00;
            hit = 1'b0;
         end
      endcase
      n.pready  = setup;
      n.pslverr = setup && !hit;
      n.prdata  = setup ? {24'h000000, rd} : 32'h00000000;
      wr        = PSEL && PENABLE && s.pready && PWRITE && !s.pslverr;
      if (wr && PADDR == A_CFG) begin
         n.cfg = PWDATA[2:0];
      end
      req0 = {wr && PADDR == A_CTRL0, wr && PADDR == A_BUF0, PWDATA[7:0]};
      req1 = {wr && PADDR == A_CTRL1, wr && PADDR == A_BUF1, PWDATA[7:0]};
      // port 1 has only timer 1; port 0 may pick timer 2
      ovf0 = s.cfg[dspm_pkg::CFG_T2SEL_BIT] ? TIMER2_OVF : TIMER1_OVF; // RULE14
   end

   always_ff @(posedge CLOCK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         s          <= '0;
         s.rxd_meta <= 2'b11;
         s.rxd_sync <= 2'b11;
         s.cfg      <= dspm_pkg::CFG_RST;
      end else begin
         s <= n;
      end
   end

   // two copies, nothing shared but the timer overflow lines
   dspm_port u_port0 ( // RULE1
      .clk     (CLOCK),
      .rst_n   (rst_n_s),
      .req     (req0),
      .rxd     (s.rxd_sync[0]),
      .ovf     (ovf0),
      .dbl     (s.cfg[dspm_pkg::CFG_DBL0_BIT]),
      .ctrl    (ctrl0),
      .rx_data (rxb0),
      .pins    (pins0)
   );

   dspm_port u_port1 ( // RULE1
      .clk     (CLOCK),
      .rst_n   (rst_n_s),
      .req     (req1),
      .rxd     (s.rxd_sync[1]),
      .ovf     (TIMER1_OVF),
      .dbl     (s.cfg[dspm_pkg::CFG_DBL1_BIT]),
      .ctrl    (ctrl1),
      .rx_data (rxb1),
      .pins    (pins1)
   );

   assign PRDATA    = s.prdata;
   assign PREADY    = s.pready;
   assign PSLVERR   = s.pslverr;
   assign TXD0      = pins0.txd;
   assign RXD0_O    = pins0.rxd_o;
   assign RXD0_OE_N = pins0.rxd_oe_n;
   assign TXD1      = pins1.txd;
   assign RXD1_O    = pins1.rxd_o;
   assign RXD1_OE_N = pins1.rxd_oe_n;

endmodule

`default_nettype wire

//--- pkg/dspm_pkg.sv
// ****************************************************************
// dual serial port constants and carriers
// ****************************************************************
package dspm_pkg;

   // register indices; the byte address on the bus is four times the index
   localparam logic [7:0]  CTRL0_IDX = 8'h98;
   localparam logic [7:0]  BUF0_IDX  = 8'h99;
   localparam logic [7:0]  CTRL1_IDX = 8'hc0;
   localparam logic [7:0]  BUF1_IDX  = 8'hc1;
   localparam logic [7:0]  CFG_IDX   = 8'hd0;
   localparam int          ADDR_W    = 12;

   // fields of the baud configuration register
   localparam int          CFG_DBL0_BIT  = 0;
   localparam int          CFG_DBL1_BIT  = 1;
   localparam int          CFG_T2SEL_BIT = 2;

   // reset values
   localparam logic [7:0]  CTRL_RST = 8'h00;
   localparam logic [2:0]  CFG_RST  = 3'h0;

   // timing in system clocks or timer overflows; oversampling in ticks per bit, frame lengths in bits
   localparam int          OVERSAMPLE       = 16;
   localparam int          M0_DIV_SLOW      = 12;
   localparam int          M0_DIV_FAST      = 4;
   localparam int          M2_BIT_SLOW      = 64;
   localparam int          M2_BIT_FAST      = 32;
   localparam int          TMR_OVF_BIT_SLOW = 32;
   localparam int          TMR_OVF_BIT_FAST = 16;
   localparam logic [3:0]  FRAME_BITS_8     = 4'ha;
   localparam logic [3:0]  FRAME_BITS_9     = 4'hb;

   typedef enum logic [1:0] {
      MODE_SHIFT, MODE_ASYNC8, MODE_ASYNC9_FIXED, MODE_ASYNC9_TIMER
   } dspm_mode_t;

   typedef enum logic [1:0] {M0_IDLE, M0_SEND, M0_RECV} dspm_m0_t;

   // control register, bit 7 first
   typedef struct packed {
      logic mode_select_high_or_frame_error;
      logic mode_select_low;
      logic clock_divide_select;
      logic rx_enable;
      logic ninth_transmit_bit;
      logic ninth_receive_bit;
      logic tx_done_flag;
      logic rx_done_flag;
   } dspm_ctrl_t;

   // register access toward one port
   typedef struct packed {
      logic       wr_ctrl;
      logic       wr_buf;
      logic [7:0] wdata;
   } dspm_req_t;

   // pin drive of one port
   typedef struct packed {
      logic txd;
      logic rxd_o;
      logic rxd_oe_n;
   } dspm_pins_t;

endpackage

//--- test/dspm_far_end.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// far-side device: async peer and clocked slave
// ****************************************************************
module dspm_far_end (
   input  wire logic clk,
   input  wire logic txd,
   input  wire logic rxd_line,
   output logic      rxd_drv
);
   // pull-up on the data line: released means high
   initial rxd_drv = 1'b1;

   // async frame out, bit 0 first; idle high afterwards
   task automatic send_frame(input logic [10:0] bits, input int n, input int per);
      for (int i = 0; i < n; i++) begin
         rxd_drv <= bits[i];
         repeat (per) @(posedge clk);
      end
      rxd_drv <= 1'b1;
   endtask

   // find the start edge, then sample each bit at its middle
   task automatic get_frame(input int n, input int per, output logic [10:0] bits);
      int t;
      t = 0;
      bits = '1;
      while (txd !== 1'b0 && t < 20000) begin
         @(posedge clk);
         t++;
      end
      repeat (per / 2) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         bits[i] = txd;
         repeat (per) @(posedge clk);
      end
   endtask

   // pure slave: never makes a clock, shifts on the one it is given
   task automatic m0_slave(input logic [7:0] dout, output logic [7:0] din, output int per);
      logic prev;
      int   t;
      int   r;
      int   f;
      int   last;
      prev = 1'b1;
      t = 0;
      r = 0;
      f = 0;
      last = 0;
      per = 0;
      while (r < 8 && t < 5000) begin
         @(posedge clk);
         t++;
         if (txd === 1'b0 && prev === 1'b1 && f < 8) begin
            rxd_drv <= dout[f];
            f++;
         end
         if (txd === 1'b1 && prev === 1'b0) begin
            din[r] = rxd_line;
            per = t - last;
            last = t;
            r++;
         end
         prev = txd;
      end
      rxd_drv <= 1'b1;
   endtask
endmodule

`default_nettype wire

//--- test/dual_serial_port_modes_bench.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// bench: two ports through the register bus and both pin pairs
// ****************************************************************
module dual_serial_port_modes_bench;
   logic        CLOCK, RST_N, PSEL, PENABLE, PWRITE, TIMER1_OVF, TIMER2_OVF;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA;
   logic        PREADY, PSLVERR, RXD0_O, RXD0_OE_N, TXD0, RXD1_O, RXD1_OE_N, TXD1;
   logic        drv0, drv1;
   wire logic   line0, line1;
   logic [31:0] v;
   logic [10:0] bits;
   logic [7:0]  din;
   logic        e;
   int          per, err_total, checks_done, cycles;

   // shared data line: design wins while its enable is low
   assign line0 = RXD0_OE_N ? drv0 : RXD0_O;
   assign line1 = RXD1_OE_N ? drv1 : RXD1_O;

   dspm_serial u_dspm_serial (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .TIMER1_OVF(TIMER1_OVF), .TIMER2_OVF(TIMER2_OVF), .RXD0_I(line0),
      .RXD0_O(RXD0_O), .RXD0_OE_N(RXD0_OE_N), .TXD0(TXD0), .RXD1_I(line1),
      .RXD1_O(RXD1_O), .RXD1_OE_N(RXD1_OE_N), .TXD1(TXD1));
   dspm_far_end u_far0 (.clk(CLOCK), .txd(TXD0), .rxd_line(line0), .rxd_drv(drv0));
   dspm_far_end u_far1 (.clk(CLOCK), .txd(TXD1), .rxd_line(line1), .rxd_drv(drv1));

   initial begin
      CLOCK = 1'b0;
      forever #20 CLOCK = ~CLOCK;
   end

   // timer 1 overflows every cycle, timer 2 every other one, so rates differ
   always @(posedge CLOCK) begin
      TIMER1_OVF <= RST_N;
      TIMER2_OVF <= RST_N & ~TIMER2_OVF;
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         err_total++;
         finish_test();
      end
   end

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic finish_test();
      if (err_total == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // one transfer; the request holds until pready is seen high
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge CLOCK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= {2'h0, idx, 2'h0};
      PWDATA <= {24'h0, wd};
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CLOCK);
      end while (PREADY !== 1'b1);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] r;
      logic        x;
      apb(1'b1, idx, d, r, x);
   endtask

   // poll a control register until a flag bit shows, bounded
   task automatic wait_flag(input logic [7:0] idx, input int b);
      int t;
      t = 0;
      do begin
         apb(1'b0, idx, 8'h00, v, e);
         t++;
      end while (v[b] !== 1'b1 && t < 300);
      chk("done flag", 32'h1, {31'h0, v[b]});
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_regs();
      apb(1'b0, dspm_pkg::CTRL0_IDX, 8'h00, v, e);
      chk("ctrl0 reset", 32'h0, v);
      wr(dspm_pkg::CTRL1_IDX, 8'hf8);
      apb(1'b0, dspm_pkg::CTRL1_IDX, 8'h00, v, e);
      chk("ctrl1 readback", 32'hf8, v);
      wr(dspm_pkg::CTRL1_IDX, 8'h00);
      apb(1'b0, 8'h9a, 8'h00, v, e);
      chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, v);
   endtask

   // clocked send on port 0 at both dividers
   task automatic t_m0_send();
      for (int s = 0; s < 2; s++) begin
         wr(dspm_pkg::CTRL0_IDX, s ? 8'h20 : 8'h00);
         fork
            wr(dspm_pkg::BUF0_IDX, 8'ha5 ^ s[7:0]);
            u_far0.m0_slave(8'hff, din, per);
         join
         chk("m0 sent byte", {24'h0, 8'ha5 ^ s[7:0]}, {24'h0, din});
         chk("m0 period", s ? 32'd4 : 32'd12, per);
         wait_flag(dspm_pkg::CTRL0_IDX, 1);
      end
   endtask

   // clocked receive on port 1, started by the control write
   task automatic t_m0_recv();
      fork
         wr(dspm_pkg::CTRL1_IDX, 8'h10);
         u_far1.m0_slave(8'h6b, din, per);
      join
      wait_flag(dspm_pkg::CTRL1_IDX, 0);
      apb(1'b0, dspm_pkg::BUF1_IDX, 8'h00, v, e);
      chk("m0 received byte", 32'h6b, v);
   endtask

   // nine-bit frames on port 1: fixed rate doubled, timer 1 rate, fixed rate plain;
   // the plain one is left running so its tick spacing is never cut short
   task automatic t_async9();
      for (int k = 0; k < 3; k++) begin
         wr(dspm_pkg::CFG_IDX, k < 2 ? 8'h02 : 8'h00);
         wr(dspm_pkg::CTRL1_IDX, k == 1 ? 8'hc8 : 8'h88);
         fork
            wr(dspm_pkg::BUF1_IDX, 8'h96);
            u_far1.get_frame(11, k == 0 ? 32 : (k == 1 ? 16 : 64), bits);
         join
         chk("nine-bit frame", {21'h0, 2'b11, 8'h96, 1'b0}, {21'h0, bits});
         wait_flag(dspm_pkg::CTRL1_IDX, 1);
      end
   endtask

   // port 0 on timer 2 with doubler: sends and receives at once
   task automatic t_duplex();
      wr(dspm_pkg::CFG_IDX, 8'h05);
      wr(dspm_pkg::CTRL0_IDX, 8'h50);
      fork
         // late start bit, so reception begins while the transmitter is busy
         begin
            repeat (8) @(posedge CLOCK);
            u_far0.send_frame({1'b0, 1'b1, 8'hc3, 1'b0}, 10, 32);
         end
         wr(dspm_pkg::BUF0_IDX, 8'h3c);
         u_far0.get_frame(10, 32, bits);
      join
      chk("ten-bit frame", {22'h0, 1'b1, 8'h3c, 1'b0}, {22'h0, bits[9:0]});
      wait_flag(dspm_pkg::CTRL0_IDX, 0);
      chk("stop bit kept", 32'h1, {31'h0, v[2]});
      apb(1'b0, dspm_pkg::BUF0_IDX, 8'h00, v, e);
      chk("received byte", 32'hc3, v);
   endtask

   initial begin
      RST_N = 1'b0;
      PSEL = 1'b0;
      PENABLE = 1'b0;
      PWRITE = 1'b0;
      PADDR = 12'h000;
      PWDATA = 32'h0;
      TIMER1_OVF = 1'b0;
      TIMER2_OVF = 1'b0;
      err_total = 0;
      checks_done = 0;
      cycles = 0;
      repeat (3) @(posedge CLOCK);
      RST_N <= 1'b1;
      repeat (3) @(posedge CLOCK);
      t_regs();
      t_m0_send();
      t_m0_recv();
      t_async9();
      t_duplex();
      finish_test();
   end
endmodule

`default_nettype wire
